// ### shared/tcpwm_defs.vh
// constants for the timer compare and pwm channel block
`ifndef TCPWM_DEFS_VH
`define TCPWM_DEFS_VH
`define TCPWM_CNT_W 16
`define TCPWM_CNT_ZERO 16'h0000
`define TCPWM_MOD_RESET 16'hFFFF
`define TCPWM_VAL_RESET 16'h0000
`define TCPWM_BYTE_W 8
`define TCPWM_DIV_W 6
`define TCPWM_DIV_ZERO 6'h00
`define TCPWM_DIV_ONES 6'h3F
`define TCPWM_PS_OFF 3'h7
`define TCPWM_ACT_NONE 2'h0
`define TCPWM_ACT_TOGGLE 2'h1
`define TCPWM_ACT_CLEAR 2'h2
`define TCPWM_ACT_SET 2'h3
`define TCPWM_MODE_CAPTURE 2'h0
`endif

// ### core/tcpwm_prescaler.v
// counter clock prescaler: one tick per selected number of bus clocks
`timescale 1ns/100ps
`include "tcpwm_defs.vh"
module tcpwm_prescaler
(
	input wire clk,
	input wire reset_n,
	input wire run,
	input wire clear,
	input wire [2:0] prescale_select,
	output wire tick
);
	reg [`TCPWM_DIV_W-1:0] div;
	wire [`TCPWM_DIV_W-1:0] mask;

	// divide by 1..64, code 7 gives no tick
	assign mask = ~(`TCPWM_DIV_ONES << prescale_select);
	assign tick = run && (prescale_select != `TCPWM_PS_OFF) && ((div & mask) == mask);

	always @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			div <= `TCPWM_DIV_ZERO;
		else if (clear)
			div <= `TCPWM_DIV_ZERO;
		else if (run)
			div <= div + 6'h01;
	end
endmodule // tcpwm_prescaler

// ### core/tcpwm_channel.v
// one channel: compare output action and event flag
`timescale 1ns/100ps
`include "tcpwm_defs.vh"
module tcpwm_channel
(
	input wire clk,
	input wire reset_n,
	input wire ovf_event,
	input wire cmp_event,
	input wire toggle_on_overflow_bit,
	input wire [1:0] compare_action,
	input wire full_duty_bit,
	input wire status_read,
	input wire flag_clear,
	input wire irq_enable,
	output reg pin_out,
	output reg flag,
	output reg irq
);
	reg armed;
	reg next_out;
	reg next_flag;

	always @*
	begin
		next_out = pin_out;
		if (ovf_event && toggle_on_overflow_bit)
			next_out = ~next_out;
		if (cmp_event)
		begin
			case (compare_action)
				`TCPWM_ACT_TOGGLE: next_out = ~next_out;
				`TCPWM_ACT_CLEAR: next_out = 1'b0;
				`TCPWM_ACT_SET: next_out = 1'b1;
				default: next_out = next_out;
			endcase
		end
		if (full_duty_bit && toggle_on_overflow_bit)
			next_out = 1'b1;
		next_flag = flag;
		if (flag_clear && armed)
			next_flag = 1'b0;
		if (cmp_event)
			next_flag = 1'b1;
	end

	always @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			pin_out <= 1'b0;
			flag <= 1'b0;
			armed <= 1'b0;
			irq <= 1'b0;
		end
		else
		begin
			pin_out <= next_out;
			flag <= next_flag;
			irq <= next_flag && irq_enable;
			if (cmp_event || flag_clear)
				armed <= 1'b0;
			else if (status_read && flag)
				armed <= 1'b1;
		end
	end
endmodule // tcpwm_channel

// ### core/tcpwm_top.v
// two-channel timer output compare and pwm, with the linked buffered pair
// Summary of operation
// - link bit pairs channels onto pin zero
// - channel zero value governs first after linking
// - channel one write switches only at overflow
// - each overflow selects last written channel
// - linked: channel one control unused, pin released
// - toggle on overflow sets pwm period
// - pulse runs overflow to compare action
// - modulo 255 gives 256 clock period
// - value 128 of 256 gives half duty
// - compare ends pulse, overflow ends period
// - buffered width change at next period
// - action 10 clears, 11 sets output
// - no overflow toggle with clear action (10) gives constant zero duty
// - full duty with toggle holds output high
// - overflow flag sets, gated interrupt request
// - channel flag on compare, gated request
// - overflow flag cleared by read then zero
// - prescale codes divide by 1 to 64
`timescale 1ns/100ps
`include "tcpwm_defs.vh"
module tcpwm_top
(
	input wire clk,
	input wire reset_n,
	input wire [2:0] prescale_select,
	input wire counter_stop_bit,
	input wire counter_reset,
	input wire overflow_irq_enable,
	input wire status_read,
	input wire overflow_flag_clear,
	input wire [7:0] data_in,
	input wire modulo_high_write,
	input wire modulo_low_write,
	input wire ch0_value_high_write,
	input wire ch0_value_low_write,
	input wire ch1_value_high_write,
	input wire ch1_value_low_write,
	input wire pair_link_mode_bit,
	input wire ch0_mode_select_lower,
	input wire [1:0] ch0_compare_action,
	input wire ch0_toggle_on_overflow_bit,
	input wire ch0_full_duty_bit,
	input wire ch0_irq_enable,
	input wire ch0_status_read,
	input wire ch0_flag_clear,
	input wire ch1_mode_select_upper,
	input wire ch1_mode_select_lower,
	input wire [1:0] ch1_compare_action,
	input wire ch1_toggle_on_overflow_bit,
	input wire ch1_full_duty_bit,
	input wire ch1_irq_enable,
	input wire ch1_status_read,
	input wire ch1_flag_clear,
	output reg [15:0] counter_value,
	output reg overflow_flag,
	output reg overflow_irq,
	output wire channel_zero_pin_out,
	output reg channel_zero_pin_oe,
	output wire channel_one_pin_out,
	output reg channel_one_pin_oe,
	output wire ch0_flag,
	output wire ch0_irq,
	output wire ch1_flag,
	output wire ch1_irq,
	output reg buffer_active_channel
);
	// link buffer states
	localparam [2:0] ST_UNLINKED = 3'h1;
	localparam [2:0] ST_ACTIVE0 = 3'h2;
	localparam [2:0] ST_ACTIVE1 = 3'h4;

	reg [2:0] state;
	reg [2:0] next_state;
	reg last_written;
	reg next_last_written;
	reg [15:0] modulo;
	reg modulo_hold;
	reg [15:0] ch0_value;
	reg [15:0] ch1_value;
	reg [7:0] ch0_high_buf;
	reg [7:0] ch1_high_buf;
	reg ch0_hold;
	reg ch1_hold;
	reg ovf_armed;
	reg next_ovf_flag;
	wire tick;
	wire at_modulo;
	wire ovf_event;
	wire [15:0] next_count;
	wire ch0_write;
	wire ch1_write;
	wire use_ch1;
	wire [15:0] ch0_compare_value;
	wire ch0_compare_hold;
	wire ch0_output_mode;
	wire ch1_output_mode;
	wire ch0_cmp_event;
	wire ch1_cmp_event;

	tcpwm_prescaler u_prescaler
	(
		.clk(clk),
		.reset_n(reset_n),
		.run(!counter_stop_bit),
		.clear(counter_reset),
		.prescale_select(prescale_select),
		.tick(tick)
	);

	assign at_modulo = (counter_value == modulo);
	assign next_count = at_modulo ? `TCPWM_CNT_ZERO : counter_value + 16'h0001;
	assign ovf_event = tick && at_modulo && !counter_reset;

	assign ch0_write = ch0_value_high_write || ch0_value_low_write;
	assign ch1_write = ch1_value_high_write || ch1_value_low_write;

	// linked pair drives only pin zero
	assign use_ch1 = pair_link_mode_bit && (state == ST_ACTIVE1);
	assign ch0_compare_value = use_ch1 ? ch1_value : ch0_value;
	assign ch0_compare_hold = use_ch1 ? ch1_hold : ch0_hold;
	assign ch0_output_mode = pair_link_mode_bit || ch0_mode_select_lower;
	assign ch1_output_mode = !pair_link_mode_bit && (ch1_mode_select_upper || ch1_mode_select_lower);

	assign ch0_cmp_event = tick && !counter_reset && ch0_output_mode && !ch0_compare_hold
		&& (next_count == ch0_compare_value);
	assign ch1_cmp_event = tick && !counter_reset && ch1_output_mode && !ch1_hold
		&& (next_count == ch1_value);

	always @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			counter_value <= `TCPWM_CNT_ZERO;
		else if (counter_reset)
			counter_value <= `TCPWM_CNT_ZERO;
		else if (tick)
			counter_value <= next_count;
	end

	// modulo: high byte write blocks the overflow flag, not the wrap, until low byte
	always @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			modulo <= `TCPWM_MOD_RESET;
			modulo_hold <= 1'b0;
		end
		else
		begin
			if (modulo_high_write)
			begin
				modulo[15:8] <= data_in;
				modulo_hold <= 1'b1;
			end
			if (modulo_low_write)
			begin
				modulo[7:0] <= data_in;
				modulo_hold <= 1'b0;
			end
		end
	end

	// channel values: high byte waits for low byte
	always @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ch0_value <= `TCPWM_VAL_RESET;
			ch1_value <= `TCPWM_VAL_RESET;
			ch0_high_buf <= 8'h00;
			ch1_high_buf <= 8'h00;
			ch0_hold <= 1'b0;
			ch1_hold <= 1'b0;
		end
		else
		begin
			if (ch0_value_high_write)
			begin
				ch0_high_buf <= data_in;
				ch0_hold <= 1'b1;
			end
			if (ch0_value_low_write)
			begin
				ch0_value <= {ch0_high_buf, data_in};
				ch0_hold <= 1'b0;
			end
			if (ch1_value_high_write)
			begin
				ch1_high_buf <= data_in;
				ch1_hold <= 1'b1;
			end
			if (ch1_value_low_write)
			begin
				ch1_value <= {ch1_high_buf, data_in};
				ch1_hold <= 1'b0;
			end
		end
	end

	// link buffer selection
	always @*
	begin
		next_state = state;
		next_last_written = last_written;
		if (ch1_write)
			next_last_written = 1'b1;
		else if (ch0_write)
			next_last_written = 1'b0;
		case (state)
			ST_UNLINKED:
			begin
				// fresh link starts on channel zero
				if (pair_link_mode_bit)
				begin
					next_state = ST_ACTIVE0;
					next_last_written = 1'b0;
				end
			end
			ST_ACTIVE0:
			begin
				// channel one takes over at overflow
				if (!pair_link_mode_bit)
					next_state = ST_UNLINKED;
				else if (ovf_event && last_written)
					next_state = ST_ACTIVE1;
			end
			ST_ACTIVE1:
			begin
				if (!pair_link_mode_bit)
					next_state = ST_UNLINKED;
				else if (ovf_event && !last_written)
					next_state = ST_ACTIVE0;
			end
			default:
				next_state = ST_UNLINKED;
		endcase
	end

	always @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state <= ST_UNLINKED;
			last_written <= 1'b0;
			buffer_active_channel <= 1'b0;
		end
		else
		begin
			state <= next_state;
			last_written <= next_last_written;
			buffer_active_channel <= (next_state == ST_ACTIVE1);
		end
	end

	always @*
	begin
		next_ovf_flag = overflow_flag;
		if (overflow_flag_clear && ovf_armed)
			next_ovf_flag = 1'b0;
		if (ovf_event && !modulo_hold)
			next_ovf_flag = 1'b1;
	end

	always @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			overflow_flag <= 1'b0;
			ovf_armed <= 1'b0;
			overflow_irq <= 1'b0;
		end
		else
		begin
			overflow_flag <= next_ovf_flag;
			overflow_irq <= next_ovf_flag && overflow_irq_enable;
			if ((ovf_event && !modulo_hold) || overflow_flag_clear)
				ovf_armed <= 1'b0;
			else if (status_read && overflow_flag)
				ovf_armed <= 1'b1;
		end
	end

	// pin drive enables follow the compare action setting
	always @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			channel_zero_pin_oe <= 1'b0;
			channel_one_pin_oe <= 1'b0;
		end
		else
		begin
			channel_zero_pin_oe <= ch0_output_mode && (ch0_compare_action != `TCPWM_ACT_NONE);
			channel_one_pin_oe <= ch1_output_mode && (ch1_compare_action != `TCPWM_ACT_NONE);
		end
	end

	tcpwm_channel u_channel0
	(
		.clk(clk),
		.reset_n(reset_n),
		.ovf_event(ovf_event && ch0_output_mode),
		.cmp_event(ch0_cmp_event),
		.toggle_on_overflow_bit(ch0_toggle_on_overflow_bit),
		.compare_action(ch0_compare_action),
		.full_duty_bit(ch0_full_duty_bit),
		.status_read(ch0_status_read),
		.flag_clear(ch0_flag_clear),
		.irq_enable(ch0_irq_enable),
		.pin_out(channel_zero_pin_out),
		.flag(ch0_flag),
		.irq(ch0_irq)
	);

	tcpwm_channel u_channel1
	(
		.clk(clk),
		.reset_n(reset_n),
		.ovf_event(ovf_event && ch1_output_mode),
		.cmp_event(ch1_cmp_event),
		.toggle_on_overflow_bit(ch1_toggle_on_overflow_bit),
		.compare_action(ch1_compare_action),
		.full_duty_bit(ch1_full_duty_bit),
		.status_read(ch1_status_read),
		.flag_clear(ch1_flag_clear),
		.irq_enable(ch1_irq_enable),
		.pin_out(channel_one_pin_out),
		.flag(ch1_flag),
		.irq(ch1_irq)
	);
endmodule // tcpwm_top

// ### sim/tcpwm_asserts.sv
// port checker for the timer compare and pwm block
`timescale 1ns/100ps
module tcpwm_asserts
(
	input wire clk,
	input wire reset_n,
	input wire [2:0] prescale_select,
	input wire counter_stop_bit,
	input wire counter_reset,
	input wire overflow_irq_enable,
	input wire ch0_irq_enable,
	input wire ch0_full_duty_bit,
	input wire ch0_toggle_on_overflow_bit,
	input wire pair_link_mode_bit,
	input wire [15:0] counter_value,
	input wire overflow_flag,
	input wire overflow_irq,
	input wire ch0_flag,
	input wire ch0_irq,
	input wire ch1_flag,
	input wire channel_zero_pin_out,
	input wire channel_zero_pin_oe,
	input wire channel_one_pin_oe,
	input wire buffer_active_channel
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	// link held for three samples
	sequence s_linked;
		pair_link_mode_bit && $past(pair_link_mode_bit) && $past(pair_link_mode_bit, 2);
	endsequence
	AST_OVF_FLAG: assert property (counter_value == 16'h0 && $past(counter_value) != 16'h0 && !$past(counter_reset) |-> overflow_flag)
		else $error("wrap without flag");
	AST_OVF_IRQ: assert property (overflow_irq |-> overflow_flag && $past(overflow_irq_enable))
		else $error("ungated ovf irq");
	AST_CH0_IRQ: assert property (ch0_irq |-> ch0_flag && $past(ch0_irq_enable))
		else $error("ungated ch0 irq");
	AST_COUNT: assert property ($past(prescale_select) == 3'h0 && !$past(counter_stop_bit) && !$past(counter_reset)
		&& counter_value != 16'h0 |-> counter_value == $past(counter_value) + 16'h1)
		else $error("bad count step");
	AST_CH1_OE: assert property (s_linked |-> !channel_one_pin_oe)
		else $error("pin one driven");
	AST_CH1_FLAG: assert property ($rose(ch1_flag) |-> !$past(pair_link_mode_bit))
		else $error("ch1 flag linked");
	AST_SEL_START: assert property ($rose(pair_link_mode_bit) |=> !buffer_active_channel)
		else $error("selector not zero");
	AST_SEL_OVF: assert property (s_linked ##0 $changed(buffer_active_channel) |-> counter_value == 16'h0)
		else $error("switch off overflow");
	AST_FULL: assert property ($past(ch0_full_duty_bit) && $past(ch0_toggle_on_overflow_bit) && channel_zero_pin_oe
		|-> channel_zero_pin_out)
		else $error("full duty low");
endmodule // tcpwm_asserts
bind tcpwm_top tcpwm_asserts chk_u (.*);

// ### sim/tcpwm_pin_meter.sv
// load on pin zero: measures period and high time
`timescale 1ns/100ps
module tcpwm_pin_meter
(
	input wire clk,
	input wire pin_out,
	input wire pin_oe,
	output logic [15:0] period,
	output logic [15:0] high_time
);
	logic [15:0] run_cnt = 16'h0;
	logic [15:0] hi_cnt = 16'h0;
	logic lvl_d = 1'h1;
	wire lvl;
	// released pin floats to the pull-up
	assign lvl = pin_oe ? pin_out : 1'h1;
	always @(posedge clk)
	begin
		lvl_d <= lvl;
		run_cnt <= (lvl && !lvl_d) ? 16'h1 : run_cnt + 16'h1;
		hi_cnt <= (lvl && !lvl_d) ? 16'h1 : hi_cnt + {15'h0, lvl};
		if (lvl && !lvl_d)
		begin
			period <= run_cnt;
			high_time <= hi_cnt;
		end
	end
endmodule // tcpwm_pin_meter

// ### sim/test_tcpwm_top.sv
// self-checking bench for the timer compare and pwm block
`timescale 1ns/100ps
module test_tcpwm_top;
	logic clk = 1'h0, reset_n = 1'h0, counter_stop_bit = 1'h1, counter_reset = 1'h0, status_read = 1'h0;
	logic overflow_irq_enable = 1'h0, overflow_flag_clear = 1'h0, pair_link_mode_bit = 1'h0, ch1_mode = 1'h0;
	logic modulo_high_write = 1'h0, modulo_low_write = 1'h0, ch0_value_high_write = 1'h0, ch0_value_low_write = 1'h0;
	logic ch1_value_high_write = 1'h0, ch1_value_low_write = 1'h0, ch0_mode_select_lower = 1'h0;
	logic ch0_irq_enable = 1'h0, ch0_toggle_on_overflow_bit = 1'h0, ch0_full_duty_bit = 1'h0;
	logic ch1_toggle_on_overflow_bit = 1'h0, ch1_full_duty_bit = 1'h0, ch1_irq_enable = 1'h0;
	logic ch1_status_read = 1'h0, ch1_flag_clear = 1'h0;
	logic [2:0] prescale_select = 3'h0;
	logic [7:0] data_in = 8'h0;
	logic [1:0] ch0_compare_action = 2'h0, ch1_compare_action = 2'h0, a;
	logic [15:0] m, v;
	wire ch0_status_read = status_read, ch0_flag_clear = overflow_flag_clear;
	wire ch1_mode_select_upper = ch1_mode, ch1_mode_select_lower = ch1_mode;
	wire [15:0] counter_value, period, high_time;
	wire overflow_flag, overflow_irq, channel_zero_pin_out, channel_zero_pin_oe, channel_one_pin_out;
	wire channel_one_pin_oe, ch0_flag, ch0_irq, ch1_flag, ch1_irq, buffer_active_channel;
	int mismatches = 0, n_compared = 0, cycles = 0, i, hi;
	tcpwm_top dut_u (.*);
	tcpwm_pin_meter meter_u (.clk(clk), .pin_out(channel_zero_pin_out), .pin_oe(channel_zero_pin_oe),
		.period(period), .high_time(high_time));
	always #12.5 clk = ~clk;
	task automatic tally_and_finish;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 30000)
		begin
			mismatches++;
			tally_and_finish;
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("BAD %0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	function automatic logic [15:0] exp_high(input logic [15:0] pm, pv, input int ps, input logic [1:0] act);
		return ((act == 2'h3) ? pm + 16'h1 - pv : pv) << ps;
	endfunction
	// w: 0 modulo, 1 channel zero, 2 channel one
	task automatic wr16(input int w, input logic [15:0] val);
		@(posedge clk);
		data_in <= val[15:8];
		{modulo_high_write, ch0_value_high_write, ch1_value_high_write} <= 3'h4 >> w;
		@(posedge clk);
		data_in <= val[7:0];
		{modulo_high_write, ch0_value_high_write, ch1_value_high_write} <= 3'h0;
		{modulo_low_write, ch0_value_low_write, ch1_value_low_write} <= 3'h4 >> w;
		@(posedge clk);
		{modulo_low_write, ch0_value_low_write, ch1_value_low_write} <= 3'h0;
	endtask
	task automatic pwm(input logic [15:0] pm, pv, input int ps, input logic [1:0] act);
		@(posedge clk);
		counter_stop_bit <= 1'h1;
		counter_reset <= 1'h1;
		@(posedge clk);
		counter_reset <= 1'h0;
		wr16(0, pm);
		wr16(1, pv);
		wr16(2, pv);
		{ch0_mode_select_lower, ch1_mode, ch0_toggle_on_overflow_bit, ch1_toggle_on_overflow_bit} <= 4'hF;
		ch0_compare_action <= act;
		ch1_compare_action <= act;
		prescale_select <= 3'(ps);
		@(posedge clk);
		counter_stop_bit <= 1'h0;
		repeat (4 * ((pm + 1) << ps)) @(posedge clk);
		@(negedge clk);
	endtask
	task automatic strobe(input logic rd);
		@(posedge clk);
		{status_read, overflow_flag_clear} <= {rd, !rd};
		@(posedge clk);
		{status_read, overflow_flag_clear} <= 2'h0;
		@(negedge clk);
	endtask
	task automatic settle_at(input logic [15:0] cv);
		for (hi = 0; hi < 5000 && counter_value !== cv; hi++)
			@(negedge clk);
	endtask
	initial
	begin
		void'($urandom(39068));
		repeat (20) @(posedge clk);
		reset_n <= 1'h1;
		@(negedge clk);
		chk({overflow_flag, ch0_flag, ch1_flag, channel_zero_pin_oe, buffer_active_channel, counter_value}, 32'h0);
		pwm(16'h00FF, 16'h0080, 0, 2'h2);
		chk(period, 32'h100);
		chk(high_time, 32'h80);
		@(posedge clk);
		counter_stop_bit <= 1'h1;
		repeat (2) @(negedge clk);
		chk({overflow_flag, overflow_irq, ch0_flag, ch0_irq}, 32'hA);
		@(posedge clk);
		overflow_irq_enable <= 1'h1;
		repeat (2) @(negedge clk);
		chk(overflow_irq, 32'h1);
		strobe(1'h0);
		chk({overflow_flag, ch0_flag}, 32'h3);
		strobe(1'h1);
		strobe(1'h0);
		chk({overflow_flag, ch0_flag}, 32'h0);
		$display("test flags done");
		@(posedge clk);
		{ch0_toggle_on_overflow_bit, counter_stop_bit, ch0_irq_enable} <= 3'h1;
		repeat (256) @(negedge clk);
		hi = 0;
		for (i = 0; i < 256; i++)
			@(negedge clk) hi += (channel_zero_pin_out !== 1'h0);
		chk(hi, 32'h0);
		chk({ch0_flag, ch0_irq}, 32'h3);
		@(posedge clk);
		{ch0_toggle_on_overflow_bit, ch0_full_duty_bit} <= 2'h3;
		repeat (256) @(negedge clk);
		hi = 0;
		for (i = 0; i < 256; i++)
			@(negedge clk) hi += (channel_zero_pin_out !== 1'h1);
		chk(hi, 32'h0);
		@(posedge clk);
		ch0_full_duty_bit <= 1'h0;
		$display("test duty limits done");
		for (i = 0; i < 7; i++)
		begin
			m = 16'h8 + 16'($urandom % 8);
			v = 16'h1 + 16'($urandom % m);
			a = 2'h2 + 2'($urandom % 2);
			pwm(m, v, i, a);
			chk(period, (m + 1) << i);
			chk(high_time, exp_high(m, v, i, a));
			chk(channel_zero_pin_out, a == 2'h2);
			chk(channel_one_pin_out, a == 2'h2);
			chk({ch1_flag, ch1_irq}, 32'h2);
		end
		@(posedge clk);
		prescale_select <= 3'h7;
		repeat (2) @(negedge clk);
		m = counter_value;
		repeat (100) @(negedge clk);
		chk(counter_value, m);
		$display("test prescale done");
		pwm(16'h003F, 16'h0014, 0, 2'h2);
		wr16(2, 16'h0028);
		@(posedge clk);
		pair_link_mode_bit <= 1'h1;
		ch1_compare_action <= 2'h3;
		repeat (256) @(negedge clk);
		chk({buffer_active_channel, channel_one_pin_oe}, 32'h0);
		chk(high_time, 32'h14);
		settle_at(16'h0005);
		wr16(2, 16'h0028);
		@(negedge clk);
		chk(buffer_active_channel, 32'h0);
		repeat (256) @(negedge clk);
		chk({buffer_active_channel, high_time}, 32'h10028);
		settle_at(16'h0005);
		wr16(1, 16'h001E);
		repeat (256) @(negedge clk);
		chk({buffer_active_channel, high_time}, 32'h1E);
		$display("test linked pair done");
		@(posedge clk);
		pair_link_mode_bit <= 1'h0;
		settle_at(16'h0000);
		wr16(1, 16'h0030);
		repeat (256) @(negedge clk);
		chk({buffer_active_channel, high_time}, 32'h30);
		$display("test unbuffered change done");
		tally_and_finish;
	end
endmodule // test_tcpwm_top
